// ===== core/cpd_power_ctrl.sv
// processing-state sequencer: reset, exception, execution, sleep and standby
`timescale 1ns/100ps
module cpd_power_ctrl #(
  parameter int unsigned OSC_WAIT_CYCLES = cpd_pkg::OSC_STAB_CYCLES,
  parameter int unsigned SLEEP_CYCLES = cpd_pkg::SLEEP_MIN_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_on_clear_n,
  input wire logic sleep_exec,
  input wire logic sleep_stall,
  input wire logic standby_select_bit,
  input wire logic port_hiz_select,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic dma_addr_err,
  input wire logic mult_busy,
  input wire logic bus_ack,
  output logic [2:0] proc_state,
  output logic cpu_halt,
  output logic cpu_run,
  output logic periph_clock_en,
  output logic periph_init,
  output logic osc_enable,
  output logic port_hold,
  output logic port_hiz,
  output logic [2:0] exc_step,
  output logic exc_is_reset,
  output logic mult_acc_invalid
);
  localparam int unsigned CW = $clog2(OSC_WAIT_CYCLES + SLEEP_CYCLES + 2);

  cpd_pkg::cpd_state_t state_q;
  cpd_pkg::cpd_state_t state_d;
  cpd_pkg::cpd_exc_step_t step_q;
  cpd_pkg::cpd_exc_step_t step_d;
  logic clear_q;
  logic entering_q;
  logic entering_d;
  logic standby_req_q;
  logic exc_reset_q;
  logic exc_reset_d;
  logic mult_bad_q;
  logic cnt_load;
  logic [CW-1:0] cnt_value;
  logic cnt_run;
  logic cnt_done;

  // clear_q is reset-loaded to 0, so a pin already high at rst release counts as a rise
  wire clear_rise = !clear_q && power_on_clear_n;
  wire in_reset = !power_on_clear_n;
  wire sleep_wake = irq_req || nmi_req || dma_addr_err;
  wire standby_wake = nmi_req;
  wire start_entry = (state_q == cpd_pkg::cpd_execute) && sleep_exec && !entering_q;
  wire entry_done = entering_q && cnt_done && !sleep_stall;
  wire exc_last = (step_q == cpd_pkg::cpd_exc_branch) && bus_ack;
  wire irq_in_exec = (state_q == cpd_pkg::cpd_execute) && !entering_q && sleep_wake;

  assign cnt_load = start_entry || (state_q == cpd_pkg::cpd_standby && standby_wake);
  assign cnt_value = start_entry ? CW'(SLEEP_CYCLES - 1) : CW'(OSC_WAIT_CYCLES);
  assign cnt_run = entering_q || (state_q == cpd_pkg::cpd_osc_wait);
  assign entering_d = start_entry ? 1'b1 : (entry_done ? 1'b0 : entering_q);

  cpd_counter #(
    .WIDTH(CW)
  ) u_wait (
    .clock(clock),
    .rst(rst),
    .load(cnt_load),
    .load_value(cnt_value),
    .run(cnt_run),
    .done(cnt_done)
  );

  // one state register guarantees exactly one processing state at a time
  always_comb begin
    state_d = state_q;
    exc_reset_d = exc_reset_q;
    if (in_reset) begin
      state_d = cpd_pkg::cpd_reset;
    end else begin
      case (state_q)
        cpd_pkg::cpd_reset: begin
          if (clear_rise) begin
            state_d = cpd_pkg::cpd_exception;
            exc_reset_d = 1'b1;
          end
        end
        cpd_pkg::cpd_exception: begin
          if (exc_last) begin
            state_d = cpd_pkg::cpd_execute;
          end
        end
        cpd_pkg::cpd_execute: begin
          if (entry_done) begin
            state_d = standby_req_q ? cpd_pkg::cpd_standby : cpd_pkg::cpd_sleep;
          end else if (irq_in_exec) begin
            state_d = cpd_pkg::cpd_exception;
            exc_reset_d = 1'b0;
          end
        end
        cpd_pkg::cpd_sleep: begin
          if (sleep_wake) begin
            state_d = cpd_pkg::cpd_exception;
            exc_reset_d = 1'b0;
          end
        end
        cpd_pkg::cpd_standby: begin
          if (standby_wake) begin
            state_d = cpd_pkg::cpd_osc_wait;
          end
        end
        cpd_pkg::cpd_osc_wait: begin
          if (cnt_done) begin
            state_d = cpd_pkg::cpd_exception;
            exc_reset_d = 1'b0;
          end
        end
        default: begin
          state_d = cpd_pkg::cpd_reset;
        end
      endcase
    end
  end

  // exception sequence: reset fetches vectors, interrupts push then fetch
  always_comb begin
    step_d = step_q;
    if (state_d != cpd_pkg::cpd_exception) begin
      step_d = cpd_pkg::cpd_exc_none;
    end else begin
      case (step_q)
        cpd_pkg::cpd_exc_none: begin
          step_d = exc_reset_d ? cpd_pkg::cpd_exc_reset_vec : cpd_pkg::cpd_exc_push_pc;
        end
        cpd_pkg::cpd_exc_reset_vec: begin
          if (bus_ack) begin
            step_d = cpd_pkg::cpd_exc_branch;
          end
        end
        cpd_pkg::cpd_exc_push_pc: begin
          if (bus_ack) begin
            step_d = cpd_pkg::cpd_exc_push_sr;
          end
        end
        cpd_pkg::cpd_exc_push_sr: begin
          if (bus_ack) begin
            step_d = cpd_pkg::cpd_exc_fetch_vec;
          end
        end
        cpd_pkg::cpd_exc_fetch_vec: begin
          if (bus_ack) begin
            step_d = cpd_pkg::cpd_exc_branch;
          end
        end
        cpd_pkg::cpd_exc_branch: begin
          step_d = step_q;
        end
        default: begin
          step_d = cpd_pkg::cpd_exc_none;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= cpd_pkg::cpd_reset;
      step_q <= cpd_pkg::cpd_exc_none;
      exc_reset_q <= 1'b0;
      entering_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      exc_reset_q <= exc_reset_d;
      entering_q <= in_reset ? 1'b0 : entering_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clear_q <= 1'b0;
      standby_req_q <= 1'b0;
      mult_bad_q <= 1'b0;
    end else begin
      clear_q <= power_on_clear_n;
      if (start_entry) begin
        standby_req_q <= standby_select_bit;
      end
      // multiply cut short by standby leaves the accumulator untrustworthy
      if (in_reset) begin
        mult_bad_q <= 1'b0;
      end else if (entry_done && standby_req_q && mult_busy) begin
        mult_bad_q <= 1'b1;
      end else if (state_q == cpd_pkg::cpd_execute && !entering_q) begin
        mult_bad_q <= 1'b0;
      end
    end
  end

  wire st_sleep = (state_q == cpd_pkg::cpd_sleep);
  wire st_sby = (state_q == cpd_pkg::cpd_standby) || (state_q == cpd_pkg::cpd_osc_wait);

  assign proc_state = state_q;
  assign exc_step = step_q;
  assign exc_is_reset = exc_reset_q;
  assign cpu_run = (state_q == cpd_pkg::cpd_execute) && !entering_q;
  assign cpu_halt = st_sleep || st_sby;
  assign periph_clock_en = !st_sby;
  assign periph_init = st_sby;
  // oscillator restarts on the edge that leaves standby for cpd_osc_wait so it can settle during the wait
  assign osc_enable = (state_q != cpd_pkg::cpd_standby);
  assign port_hold = st_sleep || (st_sby && !port_hiz_select);
  assign port_hiz = st_sby && port_hiz_select;
  assign mult_acc_invalid = mult_bad_q;
endmodule // cpd_power_ctrl

// ===== include/cpd_pkg.sv
// package for the cpu power-down control block
// What this block does
// - sleep instruction takes at least three execution cycles before low power is entered.
// - entry may stretch when fetch and data access collide or load-use stalls occur.
// - processor is always in exactly one of reset, exception, execution, power-down.
// - power_on_clear_n low places the processor in the reset state.
// - after reset, fetch program_counter and stack_pointer from vectors, then start executing.
// - interrupt pushes program_counter and status_word, fetches service vector, then resumes.
// - sleep instruction with standby_select_bit at 0 enters sleep mode.
// - sleep halts the processor; registers, memory, clock and peripherals keep running.
// - sleep ends on reset, any interrupt or dma address error, via exception processing.
// - sleep instruction with standby_select_bit at 1 enters standby mode.
// - standby stops processor, peripherals and oscillator; registers and memory kept.
// - multiply still running at standby entry leaves mult_acc_high and low undefined.
// - standby ends only on reset or nmi; other interrupts and dma errors ignored.
// - nmi wake from standby waits the oscillator stabilization time before exceptions.
// - standby port pins hold or float as configured; sleep always holds them.
// - power-on reset exception processing begins when power_on_clear_n rises.
package cpd_pkg;
  typedef enum logic [2:0] {
    cpd_reset,
    cpd_exception,
    cpd_execute,
    cpd_sleep,
    cpd_standby,
    cpd_osc_wait
  } cpd_state_t;
  typedef enum logic [2:0] {
    cpd_exc_none,
    cpd_exc_reset_vec,
    cpd_exc_push_pc,
    cpd_exc_push_sr,
    cpd_exc_fetch_vec,
    cpd_exc_branch
  } cpd_exc_step_t;
  localparam int unsigned SLEEP_MIN_CYCLES = 3;
  localparam int unsigned OSC_STAB_TIME_US = 10;
  localparam int unsigned CLOCK_MHZ = 100;
  localparam int unsigned OSC_STAB_CYCLES = OSC_STAB_TIME_US * CLOCK_MHZ;
  localparam logic [3:0] STEP_CNT_RESET = 4'h0;
endpackage

// ===== core/cpd_counter.sv
// down counter used for the sleep entry delay and the oscillator wait
`timescale 1ns/100ps
module cpd_counter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  output logic done
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  assign count_d = load ? load_value :
                   (run && count_q != '0) ? count_q - 1'b1 : count_q;
  assign done = (count_q == '0) && !load;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // cpd_counter

// ===== tb/cpd_power_ctrl_asserts.sv
// assertion checker for the power-down sequencer
`timescale 1ns/100ps
module cpd_power_ctrl_asserts #(
  parameter int unsigned OSC_WAIT_CYCLES = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_on_clear_n,
  input wire logic sleep_exec,
  input wire logic port_hiz_select,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic dma_addr_err,
  input wire logic bus_ack,
  input wire logic [2:0] proc_state,
  input wire logic cpu_halt,
  input wire logic cpu_run,
  input wire logic periph_clock_en,
  input wire logic periph_init,
  input wire logic osc_enable,
  input wire logic port_hold,
  input wire logic port_hiz,
  input wire logic [2:0] exc_step,
  input wire logic exc_is_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] osc_cnt_q;
  // counts edges spent in the oscillator wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) osc_cnt_q <= 16'h0000;
    else if (proc_state == 3'h5) osc_cnt_q <= osc_cnt_q + 16'h0001;
    else osc_cnt_q <= 16'h0000;
  end
  sequence s_run_low3;
    !cpu_run [*3];
  endsequence
  sequence s_reset_exc;
    proc_state == 3'h1 && exc_is_reset;
  endsequence
  property p_sleep_min;
    sleep_exec && cpu_run |=> s_run_low3;
  endproperty
  property p_one_state;
    proc_state <= 3'h5 && cpu_halt == (proc_state inside {3'h3, 3'h4, 3'h5});
  endproperty
  property p_clear;
    !power_on_clear_n |=> proc_state == 3'h0;
  endproperty
  property p_reset_vec;
    exc_step == 3'h1 && bus_ack && power_on_clear_n |=> exc_step == 3'h5;
  endproperty
  property p_exc_order;
    exc_step inside {3'h2, 3'h3, 3'h4} && bus_ack && power_on_clear_n
      |=> exc_step == $past(exc_step) + 3'h1;
  endproperty
  property p_branch;
    exc_step == 3'h5 && bus_ack && power_on_clear_n |=> proc_state == 3'h2;
  endproperty
  property p_sleep_wake;
    proc_state == 3'h3 && (irq_req || dma_addr_err) && power_on_clear_n |=> proc_state == 3'h1;
  endproperty
  property p_standby_stay;
    proc_state == 3'h4 && !nmi_req && power_on_clear_n |=> proc_state == 3'h4;
  endproperty
  property p_osc_wait;
    proc_state == 3'h1 && $past(proc_state) == 3'h5
      |-> osc_cnt_q >= OSC_WAIT_CYCLES - 1 && osc_cnt_q <= OSC_WAIT_CYCLES + 1;
  endproperty
  property p_standby_out;
    proc_state == 3'h4 |-> !osc_enable && !periph_clock_en && periph_init
      && port_hiz == port_hiz_select && port_hold == !port_hiz_select;
  endproperty
  property p_sleep_out;
    proc_state == 3'h3 |-> periph_clock_en && osc_enable && port_hold && !port_hiz && !cpu_run;
  endproperty
  property p_por_exc;
    $rose(power_on_clear_n) |-> ##[0:2] s_reset_exc;
  endproperty
  a_sleep_min: assert property (p_sleep_min) else $error("sleep entry too short");
  a_one_state: assert property (p_one_state) else $error("bad processing state");
  a_clear: assert property (p_clear) else $error("clear pin did not reset");
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector order");
  a_exc_order: assert property (p_exc_order) else $error("interrupt step order");
  a_branch: assert property (p_branch) else $error("no return to execute");
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake missed");
  a_standby_stay: assert property (p_standby_stay) else $error("standby left");
  a_osc_wait: assert property (p_osc_wait) else $error("oscillator wait length");
  a_standby_out: assert property (p_standby_out) else $error("standby outputs");
  a_sleep_out: assert property (p_sleep_out) else $error("sleep outputs");
  a_por_exc: assert property (p_por_exc) else $error("reset exception late");
endmodule // cpd_power_ctrl_asserts
bind cpd_power_ctrl cpd_power_ctrl_asserts #(.OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)) cpd_power_ctrl_asserts_i (.*);

// ===== tb/cpd_core_model.sv
// behavioural core answering the exception bus steps
`timescale 1ns/100ps
module cpd_core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] exc_step,
  input wire logic [3:0] ack_gap,
  output logic bus_ack
);
  logic [3:0] wait_q;
  // ack drops for a cycle after each pulse so one step is never acked twice
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (bus_ack || exc_step == 3'h0) begin
      bus_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q == ack_gap) begin
      bus_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // cpd_core_model

// ===== tb/cpd_power_ctrl_tb.sv
// self-checking bench for the power-down sequencer
`timescale 1ns/100ps
module cpd_power_ctrl_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic power_on_clear_n = 1'b0;
  logic sleep_exec = 1'b0, sleep_stall = 1'b0, standby_select_bit = 1'b0;
  logic port_hiz_select = 1'b0, irq_req = 1'b0, nmi_req = 1'b0, dma_addr_err = 1'b0;
  logic mult_busy = 1'b0, bus_ack, cpu_halt, cpu_run, periph_clock_en, periph_init;
  logic osc_enable, port_hold, port_hiz, exc_is_reset, mult_acc_invalid;
  logic [2:0] proc_state, exc_step;
  logic [3:0] ack_gap = 4'h0;
  int miscompares = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  // short oscillator wait keeps the run brief
  cpd_power_ctrl #(.OSC_WAIT_CYCLES(8)) cpd_power_ctrl_i (.*);
  cpd_core_model cpd_core_model_i (.*);
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_state(input logic [2:0] s, input int bound, output int n);
    for (n = 1; n <= bound; n++) begin
      @(posedge clock);
      #1;
      if (proc_state === s) return;
    end
    chk("wait state", s, proc_state);
    test_done();
  endtask
  task automatic t_reset();
    int n;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("state in reset", 3'h0, proc_state);
    @(posedge clock);
    power_on_clear_n <= 1'b1;
    wait_state(3'h1, 4, n);
    chk("reset kind", 3'h1, {2'b00, exc_is_reset});
    chk("vector step", 3'h1, exc_step);
    wait_state(3'h2, 20, n);
  endtask
  task automatic t_sleep(input logic stall, input logic dma);
    int n;
    @(posedge clock);
    standby_select_bit <= 1'b0;
    port_hiz_select <= 1'b1;
    ack_gap <= {1'b0, dma, 2'b11};
    sleep_exec <= 1'b1;
    sleep_stall <= stall;
    @(posedge clock);
    sleep_exec <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("halted early", 3'h0, {2'b00, cpu_halt});
    // third counted edge: entry lands here only when no stall holds it off
    @(posedge clock);
    sleep_stall <= 1'b0;
    #1;
    chk("entry stretch", {2'b00, !stall}, {2'b00, cpu_halt});
    wait_state(3'h3, 12, n);
    chk("sleep outputs", 3'h7, {periph_clock_en, osc_enable, port_hold});
    @(posedge clock);
    if (dma) dma_addr_err <= 1'b1;
    else irq_req <= 1'b1;
    wait_state(3'h1, 2, n);
    chk("first push", 3'h2, exc_step);
    @(posedge clock);
    irq_req <= 1'b0;
    dma_addr_err <= 1'b0;
    wait_state(3'h2, 60, n);
  endtask
  task automatic t_standby(input logic hiz);
    int n;
    // software has cleared the dma master enable before this point
    @(posedge clock);
    port_hiz_select <= hiz;
    standby_select_bit <= 1'b1;
    mult_busy <= 1'b1;
    sleep_exec <= 1'b1;
    @(posedge clock);
    sleep_exec <= 1'b0;
    wait_state(3'h4, 8, n);
    chk("standby clocks", 3'h1, {osc_enable, periph_clock_en, periph_init});
    chk("standby pins", {1'b0, hiz, ~hiz}, {1'b0, port_hiz, port_hold});
    chk("mult invalid", 3'h1, {2'b00, mult_acc_invalid});
    @(posedge clock);
    irq_req <= 1'b1;
    dma_addr_err <= 1'b1;
    mult_busy <= 1'b0;
    repeat (3) @(posedge clock);
    irq_req <= 1'b0;
    dma_addr_err <= 1'b0;
    #1;
    chk("standby kept", 3'h4, proc_state);
    @(posedge clock);
    if (hiz) begin
      nmi_req <= 1'b1;
      wait_state(3'h5, 2, n);
      @(posedge clock);
      nmi_req <= 1'b0;
      wait_state(3'h1, 16, n);
      chk("osc wait long", 3'h1, {2'b00, n >= 7});
    end else begin
      // reset pin stays low past the oscillator wait
      power_on_clear_n <= 1'b0;
      repeat (10) @(posedge clock);
      #1;
      chk("pin reset", 3'h0, proc_state);
      @(posedge clock);
      power_on_clear_n <= 1'b1;
      wait_state(3'h1, 4, n);
    end
    wait_state(3'h2, 60, n);
    // the flag drops one edge after execution resumes from an nmi wake, or while the reset pin is low
    @(posedge clock);
    #1;
    chk("mult cleared", 3'h0, {2'b00, mult_acc_invalid});
  endtask
  initial begin
    t_reset();
    t_sleep(1'b0, 1'b0);
    t_sleep(1'b1, 1'b1);
    t_standby(1'b1);
    t_standby(1'b0);
    test_done();
  end
endmodule // cpd_power_ctrl_tb
